// ===== hdl/btr_core.sv
// register bank and block-transfer start, burst and release control
//
// What this block does
// - later slave block cycles on second select wait 0 or 2.0..9.0 fast periods
// - six-bit burst length counts bus cycles; zero means 64
// - two-bit release mode picks request, done, bus clear or capture-and-hold
// - gap between bursts is 250 ns times the four-bit interleave field
// - direction bit set means block reads, clear means block writes for local dma
// - move enable: next bus transfer starts a block; clearing ends it
// - local-dma enable: next master write strobe is the initiation cycle
// - module dma enable: next request pin assertion starts; clearing ends it
// - byte count is high byte register joined with low byte register
// - low length bit 0 set means ignore length and run exactly one burst
// - local-dma cycles are 16 or 32 bits wide, never 8
// - writing f0 to system reset drives system reset 200 ms and resets inside
`timescale 1ns/1ps
module btr_core #(
  parameter int RESET_HOLD_CYC = btr_pkg::SYSRESET_HOLD_CYC,
  parameter int UNIT_CYC = btr_pkg::INTERLEAVE_UNIT_CYC
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [btr_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // local and system-bus events
  input wire logic sysbus_xfer_start,
  input wire logic master_write_strobe_n,
  input wire logic block_transfer_request_pin_n,
  input wire logic dma_cycle_done,
  input wire logic dma_cycle_d32,
  // system reset line, open drain
  input wire logic sysreset_n_i,
  output logic sysreset_n_o,
  output logic sysreset_n_oe,
  // control outputs
  output btr_pkg::btr_rel_t release_mode,
  output logic [6:0] burst_cycles,
  output logic [4:0] slave_block_later_cycle_delay,
  output logic dma_read,
  output logic move_block_active,
  output logic module_dma_active,
  output logic dma_start,
  output logic dma_burst_end,
  output logic dma_done,
  output logic [15:0] dma_bytes_left
);
  import btr_pkg::*;
  localparam int HW = $clog2(RESET_HOLD_CYC + 1);

  // true when the bus address selects the register with this index
  function automatic logic hit(input logic [APB_AW-1:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction : hit

  // half fast-clock periods for a timing code: 0, then 4 (2.0) up to 18 (9.0)
  function automatic logic [4:0] later_half(input logic [3:0] code);
    return (code == 4'h0) ? 5'h00 : 5'({1'b0, code} + 5'h03);
  endfunction : later_half

  logic rst_s1_r, rst_n;
  logic [7:0] rel_r, btc_r, len_hi_r, len_lo_r, ss1_r;
  logic soft_rst_r;
  logic [HW-1:0] hold_cnt_r;
  logic mwb_prev_r, blt_prev_r;
  btr_dma_t dma_st_r;
  logic single_r;
  logic [6:0] burst_cnt_r;
  logic [15:0] left_r;
  logic setup, wr_fire, mwb_fall, blt_fall;
  logic [15:0] step;
  logic last_cycle, burst_full;
  btr_timer_if tif ();

  // reset release through two flops; the first flop feeds only the second
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  assign setup = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite;
  assign mwb_fall = mwb_prev_r & ~master_write_strobe_n;
  assign blt_fall = blt_prev_r & ~block_transfer_request_pin_n;
  assign step = dma_cycle_d32 ? 16'h0004 : 16'h0002;
  assign last_cycle = single_r ? 1'b0 : (left_r <= step);
  assign burst_full = (7'(burst_cnt_r + 7'h01) == burst_cycles);

  // apb answer: decoded in setup, presented in the access cycle, no extra wait
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (setup) begin
        if (hit(paddr, IDX_RELEASE)) prdata <= {24'h000000, rel_r};
        else if (hit(paddr, IDX_BLOCK_CTL)) prdata <= {24'h000000, btc_r};
        else if (hit(paddr, IDX_LEN_HI)) prdata <= {24'h000000, len_hi_r};
        else if (hit(paddr, IDX_LEN_LO)) prdata <= {24'h000000, len_lo_r};
        else if (hit(paddr, IDX_SS1_TIMING)) prdata <= {24'h000000, ss1_r};
        else if (hit(paddr, IDX_STATUS)) begin
          prdata <= {16'h0000, sysreset_n_oe, single_r, module_dma_active,
                     move_block_active, 1'b0, dma_st_r, 8'h00} | {16'h0000, left_r};
        end else if (!hit(paddr, IDX_SYS_RESET)) pslverr <= 1'b1;
      end
    end
  end

  // configuration registers; a system reset key restores them all
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rel_r <= RELEASE_RST;
      btc_r <= BLOCK_CTL_RST;
      len_hi_r <= LEN_HI_RST;
      len_lo_r <= LEN_LO_RST;
      ss1_r <= SS1_TIMING_RST;
    end else if (ce) begin
      if (soft_rst_r) begin
        rel_r <= RELEASE_RST;
        btc_r <= BLOCK_CTL_RST;
        len_hi_r <= LEN_HI_RST;
        len_lo_r <= LEN_LO_RST;
        ss1_r <= SS1_TIMING_RST;
      end else if (wr_fire) begin
        if (hit(paddr, IDX_RELEASE)) rel_r <= pwdata[7:0];
        if (hit(paddr, IDX_BLOCK_CTL)) btc_r <= pwdata[7:0];
        if (hit(paddr, IDX_LEN_HI)) len_hi_r <= pwdata[7:0];
        if (hit(paddr, IDX_LEN_LO)) len_lo_r <= pwdata[7:0];
        if (hit(paddr, IDX_SS1_TIMING)) ss1_r <= pwdata[7:0];
      end
    end
  end

  // system reset: drive the line low for the hold count; the counter itself
  // survives the internal reset so the pulse always runs its full length
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_r <= 1'b0;
      hold_cnt_r <= '0;
      sysreset_n_oe <= 1'b0;
    end else if (ce) begin
      soft_rst_r <= 1'b0;
      if (wr_fire && hit(paddr, IDX_SYS_RESET) && pwdata[7:0] == SYSRESET_KEY) begin
        soft_rst_r <= 1'b1;
        hold_cnt_r <= HW'(RESET_HOLD_CYC);
        sysreset_n_oe <= 1'b1;
      end else if (hold_cnt_r != '0) begin
        hold_cnt_r <= hold_cnt_r - HW'(1);
        sysreset_n_oe <= (hold_cnt_r != HW'(1));
      end
    end
  end

  // registered copies of configuration seen by the transfer engines
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sysreset_n_o <= 1'b0;
      release_mode <= REL_RELEASE_ON_REQUEST;
      burst_cycles <= BURST_MAX;
      slave_block_later_cycle_delay <= 5'h00;
      dma_read <= 1'b0;
    end else if (ce) begin
      sysreset_n_o <= 1'b0;
      release_mode <= btr_rel_t'(rel_r[RELMODE_LSB +: 2]);
      burst_cycles <= (rel_r[BURST_LSB +: BURST_W] == 6'h00) ? BURST_MAX
                      : {1'b0, rel_r[BURST_LSB +: BURST_W]};
      slave_block_later_cycle_delay <= later_half(ss1_r[LATER_LSB +: LATER_W]);
      dma_read <= btc_r[DIR_BIT];
    end
  end

  // move and module-dma activity; the pins are synchronous, edges seen directly
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mwb_prev_r <= 1'b1;
      blt_prev_r <= 1'b1;
      move_block_active <= 1'b0;
      module_dma_active <= 1'b0;
    end else if (ce) begin
      mwb_prev_r <= master_write_strobe_n;
      blt_prev_r <= block_transfer_request_pin_n;
      if (!btc_r[MOVE_EN_BIT] || soft_rst_r) move_block_active <= 1'b0;
      else if (sysbus_xfer_start) move_block_active <= 1'b1;
      if (!btc_r[MDMA_EN_BIT] || soft_rst_r) module_dma_active <= 1'b0;
      else if (blt_fall) module_dma_active <= 1'b1;
    end
  end

  assign tif.periods = btc_r[ILV_LSB +: ILV_W];

  // local-dma sequencer: bursts of the set cycle count, gaps between them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dma_st_r <= DMA_IDLE;
      single_r <= 1'b0;
      burst_cnt_r <= 7'h00;
      left_r <= 16'h0000;
      dma_start <= 1'b0;
      dma_burst_end <= 1'b0;
      dma_done <= 1'b0;
      dma_bytes_left <= 16'h0000;
      tif.start <= 1'b0;
    end else if (ce) begin
      dma_start <= 1'b0;
      dma_burst_end <= 1'b0;
      dma_done <= 1'b0;
      tif.start <= 1'b0;
      dma_bytes_left <= left_r;
      if (soft_rst_r || !btc_r[LDMA_EN_BIT]) begin
        // dropping the enable abandons the transfer rather than hanging on it
        dma_st_r <= DMA_IDLE;
      end else begin
        case (dma_st_r)
          DMA_IDLE: begin
            if (mwb_fall) begin
              dma_st_r <= DMA_BURST;
              dma_start <= 1'b1;
              left_r <= {len_hi_r, len_lo_r};
              single_r <= len_lo_r[0];
              burst_cnt_r <= 7'h00;
            end
          end
          DMA_BURST: begin
            if (dma_cycle_done) begin
              left_r <= (left_r > step) ? 16'(left_r - step) : 16'h0000;
              burst_cnt_r <= 7'(burst_cnt_r + 7'h01);
              if (last_cycle) begin
                dma_st_r <= DMA_IDLE;
                dma_done <= 1'b1;
              end else if (burst_full) begin
                dma_burst_end <= 1'b1;
                burst_cnt_r <= 7'h00;
                if (single_r) begin
                  dma_st_r <= DMA_IDLE;
                  dma_done <= 1'b1;
                end else begin
                  dma_st_r <= DMA_GAP;
                  tif.start <= 1'b1;
                end
              end
            end
          end
          DMA_GAP: begin
            if (tif.done) dma_st_r <= DMA_BURST;
          end
          default: dma_st_r <= DMA_IDLE;
        endcase
      end
    end
  end

  btr_interleave_timer #(.UNIT_CYC(UNIT_CYC)) u_gap (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .tif(tif.tmr)
  );

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_ldma_trigger;
    ce && dma_st_r == DMA_IDLE && btc_r[LDMA_EN_BIT] && !soft_rst_r && mwb_fall;
  endsequence

  chk_later_delay: assert property (ce |=> slave_block_later_cycle_delay ==
      (($past(ss1_r[7:4]) == 4'h0) ? 5'h00 : 5'({1'b0, $past(ss1_r[7:4])} + 5'h03)))
    else $error("later cycle delay code mismatch");
  chk_burst_len: assert property (ce |=> burst_cycles ==
      (($past(rel_r[5:0]) == 6'h00) ? 7'h40 : {1'b0, $past(rel_r[5:0])}))
    else $error("burst length mismatch");
  chk_release_mode: assert property (ce |=> release_mode == $past(rel_r[7:6]))
    else $error("release mode mismatch");
  chk_gap_start: assert property (ce && dma_st_r == DMA_GAP && tif.done |=>
      dma_st_r == DMA_BURST || !$past(btc_r[LDMA_EN_BIT]) || $past(soft_rst_r))
    else $error("gap did not end on timer done");
  chk_move_start: assert property (ce && btc_r[MOVE_EN_BIT] && !soft_rst_r
      && sysbus_xfer_start |=> move_block_active)
    else $error("move transfer did not start");
  chk_ldma_start: assert property (s_ldma_trigger |=> dma_start && dma_st_r == DMA_BURST
      && left_r == {$past(len_hi_r), $past(len_lo_r)})
    else $error("local dma initiation missed");
  chk_mdma_end: assert property (ce && !btc_r[MDMA_EN_BIT] |=> !module_dma_active)
    else $error("module dma not ended");
  chk_single_burst: assert property (ce && dma_st_r == DMA_BURST && single_r
      && dma_cycle_done && burst_full && btc_r[LDMA_EN_BIT] && !soft_rst_r
      |=> dma_done && dma_st_r == DMA_IDLE)
    else $error("single burst did not finish");
  chk_sysreset_hold: assert property (ce && wr_fire && hit(paddr, IDX_SYS_RESET)
      && pwdata[7:0] == SYSRESET_KEY |=> sysreset_n_oe [*8])
    else $error("system reset not held");
  chk_apb_answer: assert property (ce && setup |=> pready)
    else $error("apb answer missing");
endmodule : btr_core

// ===== hdl/btr_interleave_timer.sv
// interleave gap timer: periods times the 250 ns unit, then a done pulse
`timescale 1ns/1ps
module btr_interleave_timer #(
  parameter int UNIT_CYC = btr_pkg::INTERLEAVE_UNIT_CYC
) (
  // clock and control
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // request and completion
  btr_timer_if.tmr tif
);
  import btr_pkg::*;
  localparam int CW = $clog2(UNIT_CYC * 16 + 1);
  logic [CW-1:0] cnt_r;
  logic run_r;

  // count the gap; a zero field finishes one cycle after the start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      tif.done <= 1'b0;
    end else if (ce) begin
      tif.done <= 1'b0;
      if (tif.start) begin
        cnt_r <= CW'(32'(tif.periods) * UNIT_CYC);
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r <= CW'(1)) begin
          run_r <= 1'b0;
          cnt_r <= '0;
          tif.done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - CW'(1);
        end
      end
    end
  end
endmodule : btr_interleave_timer

// ===== hdl/btr_pkg.sv
// constants, field layout and types shared by the block-transfer release control files
package btr_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_SS1_TIMING = 8'hcf;
  localparam logic [7:0] IDX_RELEASE = 8'hd3;
  localparam logic [7:0] IDX_BLOCK_CTL = 8'hd7;
  localparam logic [7:0] IDX_LEN_HI = 8'hdb;
  localparam logic [7:0] IDX_LEN_LO = 8'hdf;
  localparam logic [7:0] IDX_SYS_RESET = 8'he3;
  localparam logic [7:0] IDX_STATUS = 8'he7;
  localparam int APB_AW = 12;
  // field positions
  localparam int BURST_LSB = 0;
  localparam int BURST_W = 6;
  localparam int RELMODE_LSB = 6;
  localparam int ILV_LSB = 0;
  localparam int ILV_W = 4;
  localparam int DIR_BIT = 4;
  localparam int MOVE_EN_BIT = 5;
  localparam int LDMA_EN_BIT = 6;
  localparam int MDMA_EN_BIT = 7;
  localparam int LATER_LSB = 4;
  localparam int LATER_W = 4;
  // reset values
  localparam logic [7:0] RELEASE_RST = 8'h00;
  localparam logic [7:0] BLOCK_CTL_RST = 8'h00;
  localparam logic [7:0] LEN_HI_RST = 8'h00;
  localparam logic [7:0] LEN_LO_RST = 8'h00;
  localparam logic [7:0] SS1_TIMING_RST = 8'h00;
  localparam logic [7:0] SYSRESET_KEY = 8'hf0;
  localparam logic [6:0] BURST_MAX = 7'h40;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SYSRESET_HOLD_MS = 200;
  localparam int SYSRESET_HOLD_CYC = SYSRESET_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int INTERLEAVE_UNIT_NS = 250;
  localparam int INTERLEAVE_UNIT_CYC = (INTERLEAVE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bus release modes
  typedef enum logic [1:0] {
    REL_RELEASE_ON_REQUEST = 2'b00,
    REL_RELEASE_WHEN_DONE = 2'b01,
    REL_RELEASE_ON_BUS_CLEAR = 2'b10,
    REL_CAPTURE_AND_HOLD = 2'b11
  } btr_rel_t;
  // local-dma sequencer states
  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_BURST = 3'b010,
    DMA_GAP = 3'b100
  } btr_dma_t;
endpackage : btr_pkg

// ===== hdl/btr_timer_if.sv
// interleave timer request and completion between the control core and the timer
`timescale 1ns/1ps
interface btr_timer_if;
  logic start;
  logic [3:0] periods;
  logic done;
  modport ctl (output start, output periods, input done);
  modport tmr (input start, input periods, output done);
endinterface : btr_timer_if

// ===== verification/btr_far_side.sv
// far-side model: local strobe, request pin, bus transfer pulses, dma cycle completions
`timescale 1ns/1ps
module btr_far_side (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // commands from the bench
  input wire logic fire_mws,
  input wire logic fire_blt,
  input wire logic fire_xfer,
  input wire logic d32,
  input wire logic [2:0] dwell,
  input wire logic [7:0] gap,
  // design side
  input wire logic dma_start,
  input wire logic dma_burst_end,
  input wire logic dma_done,
  output logic master_write_strobe_n,
  output logic block_transfer_request_pin_n,
  output logic sysbus_xfer_start,
  output logic dma_cycle_done,
  output logic dma_cycle_d32,
  output int sent
);
  logic run_r;
  logic [2:0] wait_r;
  logic [7:0] pause_r;
  // cycle width is only ever 16 or 32 bits
  assign dma_cycle_d32 = d32;
  // strobe and pin idle high, low for one cycle on command
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      master_write_strobe_n <= 1'b1;
      block_transfer_request_pin_n <= 1'b1;
      sysbus_xfer_start <= 1'b0;
    end else begin
      master_write_strobe_n <= !fire_mws;
      block_transfer_request_pin_n <= !fire_blt;
      sysbus_xfer_start <= fire_xfer;
    end
  end
  // one completion every dwell+1 cycles; dwell of 1 or more lets done land before a spare pulse
  // after a burst end the model rests for the gap count, so a design gap that runs
  // longer than the rules allow swallows pulses and the count shows it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_r <= 1'b0;
      wait_r <= 3'h0;
      pause_r <= 8'h00;
      dma_cycle_done <= 1'b0;
      sent <= 0;
    end else begin
      dma_cycle_done <= 1'b0;
      if (dma_start) begin
        run_r <= 1'b1;
        sent <= 0;
        wait_r <= dwell;
        pause_r <= 8'h00;
      end else if (dma_done) begin
        run_r <= 1'b0;
        pause_r <= 8'h00;
      end else if (dma_burst_end) begin
        run_r <= 1'b0;
        pause_r <= gap;
      end else if (pause_r != 8'h00) begin
        pause_r <= pause_r - 8'h01;
        if (pause_r == 8'h01) begin
          run_r <= 1'b1;
          wait_r <= dwell;
        end
      end else if (run_r) begin
        if (wait_r != 3'h0) begin
          wait_r <= wait_r - 3'h1;
        end else begin
          dma_cycle_done <= 1'b1;
          sent <= sent + 1;
          wait_r <= dwell;
        end
      end
    end
  end
endmodule : btr_far_side

// ===== verification/test_block_transfer_release_control.sv
// self-checking bench for the block-transfer release control core
`timescale 1ns/1ps
module test_block_transfer_release_control;
  import btr_pkg::*;
  localparam int HOLD = 20;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic fire_mws = 1'b0;
  logic fire_blt = 1'b0;
  logic fire_xfer = 1'b0;
  logic d32 = 1'b0;
  logic [2:0] dwell = 3'h2;
  logic [7:0] gap = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, mws_n, blt_n, xfer, cyc_done, cyc_d32, rst_o, rst_oe;
  logic dma_read, move_act, mod_act, dma_start, burst_end, dma_done;
  logic [6:0] burst_cycles;
  logic [4:0] later;
  logic [15:0] bytes_left;
  btr_rel_t release_mode;
  int sent;
  int seed = 10;
  int mismatches = 0;
  int checks_done = 0;
  // open-drain reset line with pull-up
  wire logic rst_line = rst_oe ? rst_o : 1'b1;

  always #4 clk_sys = ~clk_sys;

  btr_core #(.RESET_HOLD_CYC(HOLD), .UNIT_CYC(2)) u_btr_core (
    .clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysbus_xfer_start(xfer), .master_write_strobe_n(mws_n),
    .block_transfer_request_pin_n(blt_n), .dma_cycle_done(cyc_done),
    .dma_cycle_d32(cyc_d32), .sysreset_n_i(rst_line), .sysreset_n_o(rst_o),
    .sysreset_n_oe(rst_oe), .release_mode(release_mode), .burst_cycles(burst_cycles),
    .slave_block_later_cycle_delay(later), .dma_read(dma_read),
    .move_block_active(move_act), .module_dma_active(mod_act), .dma_start(dma_start),
    .dma_burst_end(burst_end), .dma_done(dma_done), .dma_bytes_left(bytes_left));

  btr_far_side u_btr_far_side (
    .clk_sys(clk_sys), .rstn(rstn), .fire_mws(fire_mws), .fire_blt(fire_blt),
    .fire_xfer(fire_xfer), .d32(d32), .dwell(dwell), .gap(gap), .dma_start(dma_start),
    .dma_burst_end(burst_end), .dma_done(dma_done), .master_write_strobe_n(mws_n),
    .block_transfer_request_pin_n(blt_n), .sysbus_xfer_start(xfer),
    .dma_cycle_done(cyc_done), .dma_cycle_d32(cyc_d32), .sent(sent));

  // expectations
  function automatic logic [31:0] later_exp(input int c);
    return (c == 0) ? 32'h0 : 32'(c + 3);
  endfunction : later_exp
  function automatic logic [31:0] burst_exp(input logic [5:0] f);
    return (f == 6'h0) ? 32'h40 : {26'h0, f};
  endfunction : burst_exp

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
    // the output copies follow one edge after the write lands
    repeat (2) @(posedge clk_sys);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp, "read data");
    chk(e, experr, "slave error");
  endtask : rdchk

  // local dma run: trigger, then count completions up to done
  task automatic run_dma(input int exp, input logic [15:0] left);
    int n;
    n = 0;
    fire_mws <= 1'b1;
    @(posedge clk_sys);
    fire_mws <= 1'b0;
    while (dma_start !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 10, 1, "dma start");
    n = 0;
    while (dma_done !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(sent, exp, "cycles to done");
    chk(dma_done, 1, "dma done");
    repeat (2) @(posedge clk_sys);
    chk(bytes_left, left, "bytes left");
  endtask : run_dma

  // a hang ends the run as a failure
  initial begin
    #(8 * 40000);
    mismatches++;
    conclude();
  end

  initial begin
    logic [31:0] v;
    logic [15:0] len;
    logic [7:0] idxs [6];
    logic e;
    int n;
    idxs = '{IDX_SS1_TIMING, IDX_RELEASE, IDX_BLOCK_CTL, IDX_LEN_HI, IDX_LEN_LO, IDX_SYS_RESET};
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (idxs[i]) rdchk(idxs[i], 32'h0, 1'b0);
    chk(burst_cycles, 32'h40, "burst after reset");
    $display("test reset values done");
    // every release mode, zero burst field as a corner
    for (int i = 0; i < 8; i++) begin
      v = 32'($random(seed)) & 32'hff;
      if (i < 2) v[5:0] = 6'h0;
      v[7:6] = 2'(i);
      wr(IDX_RELEASE, v);
      chk(release_mode, v[7:6], "release mode");
      chk(burst_cycles, burst_exp(v[5:0]), "burst count");
      rdchk(IDX_RELEASE, v, 1'b0);
    end
    $display("test release and burst done");
    for (int c = 0; c < 16; c++) begin
      wr(IDX_SS1_TIMING, {24'h0, 4'(c), 4'($random(seed))});
      chk(later, later_exp(c), "later cycle delay");
    end
    apb(1'b1, 8'h10, 32'hff, v, e);
    chk(e, 1, "unmapped write");
    rdchk(8'h10, 32'h0, 1'b1);
    $display("test delay codes and unmapped done");
    // move: armed, then started by a bus transfer, ended by clearing
    wr(IDX_BLOCK_CTL, 32'h20);
    chk(move_act, 0, "move before transfer");
    fire_xfer <= 1'b1;
    @(posedge clk_sys);
    fire_xfer <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(move_act, 1, "move started");
    wr(IDX_BLOCK_CTL, 32'h0);
    chk(move_act, 0, "move ended");
    wr(IDX_BLOCK_CTL, 32'h80);
    fire_blt <= 1'b1;
    @(posedge clk_sys);
    fire_blt <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(mod_act, 1, "module dma started");
    wr(IDX_BLOCK_CTL, 32'h0);
    chk(mod_act, 0, "module dma ended");
    $display("test move and module dma done");
    // local dma, one burst of 64 cycles at most; last case uses the high byte
    wr(IDX_RELEASE, 32'h0);
    for (int t = 0; t < 4; t++) begin
      len = 16'((($random(seed) & 63) + 1) * 2);
      if (t == 3) len = 16'h0100;
      d32 <= t[1];
      dwell <= 3'(2 + 2 * t[0]);
      wr(IDX_LEN_HI, {24'h0, len[15:8]});
      wr(IDX_LEN_LO, {24'h0, len[7:0]});
      wr(IDX_BLOCK_CTL, {25'h0, 1'b1, 1'b0, t[0], 4'h3});
      chk(dma_read, t[0], "direction");
      run_dma((int'(len) + (t[1] ? 3 : 1)) / (t[1] ? 4 : 2), 16'h0000);
      wr(IDX_BLOCK_CTL, 32'h0);
    end
    // odd length: one burst of five 16-bit cycles only, 0x141 less ten bytes left
    d32 <= 1'b0;
    wr(IDX_RELEASE, 32'h05);
    wr(IDX_LEN_HI, 32'h01);
    wr(IDX_LEN_LO, 32'h41);
    wr(IDX_BLOCK_CTL, 32'h40);
    run_dma(5, 16'h0137);
    wr(IDX_BLOCK_CTL, 32'h0);
    // four-cycle bursts over 40 bytes: five bursts, four gaps of three units
    wr(IDX_RELEASE, 32'h04);
    wr(IDX_LEN_HI, 32'h00);
    wr(IDX_LEN_LO, 32'h28);
    gap <= 8'h06; // three interleave units of two cycles each
    wr(IDX_BLOCK_CTL, 32'h43);
    run_dma(20, 16'h0000);
    wr(IDX_BLOCK_CTL, 32'h0);
    $display("test local dma done");
    // reset key: line pulled low for the hold count, registers back to reset
    wr(IDX_RELEASE, 32'hc5);
    apb(1'b1, IDX_SYS_RESET, 32'hf0, v, e);
    @(posedge clk_sys);
    n = 0;
    while (rst_oe === 1'b1 && n < 200) begin
      chk(rst_line, 0, "reset line low");
      @(posedge clk_sys);
      n++;
    end
    chk(n >= HOLD && n < 200, 1, "reset hold");
    chk(release_mode, 0, "mode after key");
    rdchk(IDX_RELEASE, 32'h0, 1'b0);
    $display("test system reset done");
    conclude();
  end
endmodule : test_block_transfer_release_control
